// file: hw/adp_map.svh
// Bit positions, reset values and widths of the adapter registers
`ifndef ADP_MAP_SVH
`define ADP_MAP_SVH

// Control register bit positions
`define ADP_CR_FLAG_FIRST   7
`define ADP_CR_FLAG_SECOND  6
`define ADP_CR_SEC_MODE     5
`define ADP_CR_SEC_EDGE     4
`define ADP_CR_SEC_ENABLE   3
`define ADP_CR_ACCESS       2
`define ADP_CR_FIRST_EDGE   1
`define ADP_CR_FIRST_ENABLE 0

// Writable part of a control register
`define ADP_CR_WR_HI        5
`define ADP_CR_WR_LO        0

// Reset values
`define ADP_REG_RST         8'h00
`define ADP_CFG_RST         6'h00
`define ADP_SYNC_RST        3'h0

// Width of a register and of a port side
`define ADP_REG_W           8

`endif

// file: hw/adp_pkg.sv
// Types shared by the adapter design files
`default_nettype none
package adp_pkg;

  // Bus cycle tracking against the bus clock level
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_HIGH = 1'b1
  } bus_state_t;

  // Register select codes: high select line, low select line
  typedef enum logic [1:0] {
    SEL_A_DATA = 2'b00,
    SEL_A_CTL  = 2'b01,
    SEL_B_DATA = 2'b10,
    SEL_B_CTL  = 2'b11
  } reg_sel_t;

endpackage
`default_nettype wire

// file: hw/side_ctl.sv
// One side: control register, interrupt flags, edge detect, control line
`timescale 1ns/100ps
`default_nettype none
`include "adp_map.svh"
module side_ctl (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register access
  input  wire logic       ctl_wr_i,
  input  wire logic [7:0] ctl_data_i,
  input  wire logic       flag_clr_i,
  output logic      [7:0] ctl_reg_o,
  // Control lines
  input  wire logic       ctl_first_i,
  input  wire logic       ctl_second_i,
  output logic            ctl_second_o,
  output logic            ctl_second_oe_o,
  // Interrupt pull-down
  output logic            irq_oe_o
);

  logic [5:0] cfg_ff;
  logic [5:0] nxt_cfg;
  logic       flag_first_ff;
  logic       nxt_flag_first;
  logic       flag_second_ff;
  logic       nxt_flag_second;
  logic [2:0] first_sync_ff;
  logic [2:0] nxt_first_sync;
  logic [2:0] second_sync_ff;
  logic [2:0] nxt_second_sync;
  logic       first_act;
  logic       second_act;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection after a two-stage synchroniser
  always_comb begin
    nxt_first_sync  = {first_sync_ff[1:0], ctl_first_i};
    nxt_second_sync = {second_sync_ff[1:0], ctl_second_i};
    // Polarity bit picks rising (1) or falling (0) as active
    first_act = cfg_ff[`ADP_CR_FIRST_EDGE] ?
                (first_sync_ff[1] & ~first_sync_ff[2]) :
                (~first_sync_ff[1] & first_sync_ff[2]);
    // Second line only raises its flag while it is an input
    second_act = ~cfg_ff[`ADP_CR_SEC_MODE] &
                 (cfg_ff[`ADP_CR_SEC_EDGE] ?
                  (second_sync_ff[1] & ~second_sync_ff[2]) :
                  (~second_sync_ff[1] & second_sync_ff[2]));
    // Set beats clear so an edge during a port read is not lost
    nxt_flag_first  = first_act | (flag_first_ff & ~flag_clr_i);
    nxt_flag_second = second_act | (flag_second_ff & ~flag_clr_i);
    nxt_cfg = ctl_wr_i ? ctl_data_i[`ADP_CR_WR_HI:`ADP_CR_WR_LO] :
              cfg_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff         <= `ADP_CFG_RST;
      flag_first_ff  <= 1'b0;
      flag_second_ff <= 1'b0;
      first_sync_ff  <= `ADP_SYNC_RST;
      second_sync_ff <= `ADP_SYNC_RST;
    end else begin
      cfg_ff         <= nxt_cfg;
      flag_first_ff  <= nxt_flag_first;
      flag_second_ff <= nxt_flag_second;
      first_sync_ff  <= nxt_first_sync;
      second_sync_ff <= nxt_second_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign ctl_reg_o = {flag_first_ff, flag_second_ff, cfg_ff};
  // Handshake modes are not built; output mode drives the enable bit level
  assign ctl_second_oe_o = cfg_ff[`ADP_CR_SEC_MODE];
  assign ctl_second_o    = cfg_ff[`ADP_CR_SEC_ENABLE];
  assign irq_oe_o = (flag_first_ff & cfg_ff[`ADP_CR_FIRST_ENABLE]) |
                    (flag_second_ff & cfg_ff[`ADP_CR_SEC_ENABLE]);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_first_flag_set: assert property (
    first_act |=> flag_first_ff
  ) else $error("first flag not set after active edge");

  a_flag_read_clear: assert property (
    (flag_clr_i && !first_act && !second_act) |=>
      !flag_first_ff && !flag_second_ff
  ) else $error("flags not cleared by port read");

  a_irq_masked: assert property (
    (!cfg_ff[`ADP_CR_FIRST_ENABLE] && !cfg_ff[`ADP_CR_SEC_ENABLE])
      |-> !irq_oe_o
  ) else $error("interrupt asserted while both sources disabled");

  a_sync_latency: assert property (
    ($rose(ctl_first_i) && cfg_ff[`ADP_CR_FIRST_EDGE] && !ctl_wr_i)
      ##1 (!ctl_wr_i && !flag_clr_i)[*2] |=> flag_first_ff
  ) else $error("synchronised edge did not set flag in three cycles");

endmodule
`default_nettype wire

// file: hw/dual_port_parallel_io_adapter.sv
// Dual-side parallel I/O adapter on a clocked 8-bit processor bus
//
// Behaviour
// - Low reset pin clears every register
// - Transfers timed by bus clock high phase
// - Direction high reads, low writes
// - Data lines driven only during selected read
// - Selected when two selects high, third low
// - One open-drain active-low request per side
// - Sides A and B fully independent
// - Write latched high phase, stored after fall
// - Control bits 7,6 flags; 5-3, 1-0 configure
// - Control bit 2 steers port-data address
// - Output lines follow output register bits
// - Status logic detects edges, drives second line
// - Control registers configure inputs and outputs
// - Bit 2 one: output register, zero: direction
// - Select codes 00,01,10,11 map A/B data/control
// - Port read clears that side's two flags
// - Control bits 0 and 3 gate interrupts
`timescale 1ns/100ps
`default_nettype none
`include "adp_map.svh"
module dual_port_parallel_io_adapter #(
  parameter int PORT_W = `ADP_REG_W
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              reset_in_n_i,
  // Processor bus
  input  wire logic              bus_phase_i,
  input  wire logic              rd_wr_i,
  input  wire logic              select_hi_first_i,
  input  wire logic              select_hi_second_i,
  input  wire logic              select_lo_n_i,
  input  wire logic              reg_sel_low_i,
  input  wire logic              reg_sel_high_i,
  input  wire logic [PORT_W-1:0] host_data_lines_i,
  output logic      [PORT_W-1:0] host_data_lines_o,
  output logic                   host_data_lines_oe_o,
  // Interrupt requests, open drain
  output logic                   side_a_irq_n_o,
  output logic                   side_a_irq_n_oe_o,
  output logic                   side_b_irq_n_o,
  output logic                   side_b_irq_n_oe_o,
  // Side A lines
  input  wire logic [PORT_W-1:0] side_a_port_lines_i,
  output logic      [PORT_W-1:0] side_a_port_lines_o,
  output logic      [PORT_W-1:0] side_a_port_lines_oe_o,
  input  wire logic              side_a_ctl_first_i,
  input  wire logic              side_a_ctl_second_i,
  output logic                   side_a_ctl_second_o,
  output logic                   side_a_ctl_second_oe_o,
  // Side B lines
  input  wire logic [PORT_W-1:0] side_b_port_lines_i,
  output logic      [PORT_W-1:0] side_b_port_lines_o,
  output logic      [PORT_W-1:0] side_b_port_lines_oe_o,
  input  wire logic              side_b_ctl_first_i,
  input  wire logic              side_b_ctl_second_i,
  output logic                   side_b_ctl_second_o,
  output logic                   side_b_ctl_second_oe_o
);

  // Control register layout is fixed at one byte
  if (PORT_W != `ADP_REG_W) begin : g_width_check
    $error("PORT_W must equal the register width");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                          rst;
  logic                          sel_now;
  adp_pkg::reg_sel_t             rs_now;
  adp_pkg::bus_state_t           st_ff;
  adp_pkg::bus_state_t           nxt_st;
  logic                          lat_sel_ff;
  logic                          nxt_lat_sel;
  logic                          lat_rw_ff;
  logic                          nxt_lat_rw;
  adp_pkg::reg_sel_t             lat_rs_ff;
  adp_pkg::reg_sel_t             nxt_lat_rs;
  logic [PORT_W-1:0]             in_latch_ff;
  logic [PORT_W-1:0]             nxt_in_latch;
  logic [PORT_W-1:0]             rd_data_ff;
  logic [PORT_W-1:0]             nxt_rd_data;
  logic                          fall;
  logic                          wr_commit;
  logic                          rd_commit;
  logic [1:0][PORT_W-1:0]        ddr_ff;
  logic [1:0][PORT_W-1:0]        nxt_ddr;
  logic [1:0][PORT_W-1:0]        out_ff;
  logic [1:0][PORT_W-1:0]        nxt_out;
  logic [1:0][PORT_W-1:0]        pin_in;
  logic [1:0][PORT_W-1:0]        port_rd;
  logic [1:0][`ADP_REG_W-1:0]    cr;
  logic [1:0]                    ctl_wr;
  logic [1:0]                    data_wr;
  logic [1:0]                    flag_clr;
  logic [1:0]                    ctl_first;
  logic [1:0]                    ctl_second;
  logic [1:0]                    sec_o;
  logic [1:0]                    sec_oe;
  logic [1:0]                    irq_oe;

  // Either reset source clears the whole adapter
  assign rst = reset_i | ~reset_in_n_i;

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle decode
  assign sel_now = select_hi_first_i & select_hi_second_i &
                   ~select_lo_n_i;
  assign rs_now = adp_pkg::reg_sel_t'({reg_sel_high_i, reg_sel_low_i});

  always_comb begin
    nxt_st       = st_ff;
    nxt_lat_sel  = lat_sel_ff;
    nxt_lat_rw   = lat_rw_ff;
    nxt_lat_rs   = lat_rs_ff;
    nxt_in_latch = in_latch_ff;
    unique case (st_ff)
      adp_pkg::ST_IDLE: begin
        if (bus_phase_i) begin
          nxt_st = adp_pkg::ST_HIGH;
        end
      end
      adp_pkg::ST_HIGH: begin
        if (!bus_phase_i) begin
          nxt_st = adp_pkg::ST_IDLE;
        end
      end
    endcase
    // Sample address and direction through the whole high phase
    if (bus_phase_i) begin
      nxt_lat_sel = sel_now;
      nxt_lat_rw  = rd_wr_i;
      nxt_lat_rs  = rs_now;
      if (sel_now && !rd_wr_i) begin
        nxt_in_latch = host_data_lines_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst) begin
      st_ff       <= adp_pkg::ST_IDLE;
      lat_sel_ff  <= 1'b0;
      lat_rw_ff   <= 1'b1;
      lat_rs_ff   <= adp_pkg::SEL_A_DATA;
      in_latch_ff <= `ADP_REG_RST;
    end else begin
      st_ff       <= nxt_st;
      lat_sel_ff  <= nxt_lat_sel;
      lat_rw_ff   <= nxt_lat_rw;
      lat_rs_ff   <= nxt_lat_rs;
      in_latch_ff <= nxt_in_latch;
    end
  end

  // Register effects wait for the falling edge so port lines move once
  assign fall      = (st_ff == adp_pkg::ST_HIGH) & ~bus_phase_i;
  assign wr_commit = fall & lat_sel_ff & ~lat_rw_ff;
  assign rd_commit = fall & lat_sel_ff & lat_rw_ff;

  ////////////////////////////////////////////////////////////////////////
  // Direction and output registers
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      ctl_wr[s]   = wr_commit & (lat_rs_ff[1] == s[0]) &
                    lat_rs_ff[0];
      data_wr[s]  = wr_commit & (lat_rs_ff[1] == s[0]) &
                    ~lat_rs_ff[0];
      flag_clr[s] = rd_commit & (lat_rs_ff[1] == s[0]) & ~lat_rs_ff[0] &
                    cr[s][`ADP_CR_ACCESS];
      nxt_out[s] = (data_wr[s] && cr[s][`ADP_CR_ACCESS]) ?
                   in_latch_ff : out_ff[s];
      nxt_ddr[s] = (data_wr[s] && !cr[s][`ADP_CR_ACCESS]) ?
                   in_latch_ff : ddr_ff[s];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst) begin
      ddr_ff <= '0;
      out_ff <= '0;
    end else begin
      ddr_ff <= nxt_ddr;
      out_ff <= nxt_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-side status logic
  assign pin_in[0]     = side_a_port_lines_i;
  assign pin_in[1]     = side_b_port_lines_i;
  assign ctl_first[0]  = side_a_ctl_first_i;
  assign ctl_first[1]  = side_b_ctl_first_i;
  assign ctl_second[0] = side_a_ctl_second_i;
  assign ctl_second[1] = side_b_ctl_second_i;

  // Side A reads its pins; side B reads its own register on output lines
  assign port_rd[0] = pin_in[0];
  assign port_rd[1] = (ddr_ff[1] & out_ff[1]) | (~ddr_ff[1] & pin_in[1]);

  for (genvar g = 0; g < 2; g++) begin : g_side
    side_ctl u_side (
      .clk_i           (sys_clk_i),
      .rst_i           (rst),
      .ctl_wr_i        (ctl_wr[g]),
      .ctl_data_i      (in_latch_ff),
      .flag_clr_i      (flag_clr[g]),
      .ctl_reg_o       (cr[g]),
      .ctl_first_i     (ctl_first[g]),
      .ctl_second_i    (ctl_second[g]),
      .ctl_second_o    (sec_o[g]),
      .ctl_second_oe_o (sec_oe[g]),
      .irq_oe_o        (irq_oe[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    nxt_rd_data = rd_data_ff;
    unique case (rs_now)
      adp_pkg::SEL_A_DATA: begin
        nxt_rd_data = cr[0][`ADP_CR_ACCESS] ? port_rd[0] : ddr_ff[0];
      end
      adp_pkg::SEL_A_CTL: begin
        nxt_rd_data = cr[0];
      end
      adp_pkg::SEL_B_DATA: begin
        nxt_rd_data = cr[1][`ADP_CR_ACCESS] ? port_rd[1] : ddr_ff[1];
      end
      adp_pkg::SEL_B_CTL: begin
        nxt_rd_data = cr[1];
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst) begin
      rd_data_ff <= `ADP_REG_RST;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Read data trails the select by one clock; the high phase spans several
  assign host_data_lines_o    = rd_data_ff;
  assign host_data_lines_oe_o = sel_now & rd_wr_i & bus_phase_i;

  ////////////////////////////////////////////////////////////////////////
  // Pins
  assign side_a_port_lines_o    = out_ff[0];
  assign side_a_port_lines_oe_o = ddr_ff[0];
  assign side_b_port_lines_o    = out_ff[1];
  assign side_b_port_lines_oe_o = ddr_ff[1];
  assign side_a_ctl_second_o    = sec_o[0];
  assign side_a_ctl_second_oe_o = sec_oe[0];
  assign side_b_ctl_second_o    = sec_o[1];
  assign side_b_ctl_second_oe_o = sec_oe[1];
  // Open drain: only ever pull low, so lines can be wired together
  assign side_a_irq_n_o    = 1'b0;
  assign side_a_irq_n_oe_o = irq_oe[0];
  assign side_b_irq_n_o    = 1'b0;
  assign side_b_irq_n_oe_o = irq_oe[1];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst);

  a_bus_drive_read: assert property (
    host_data_lines_oe_o |-> (select_hi_first_i && select_hi_second_i &&
                              !select_lo_n_i && rd_wr_i)
  ) else $error("data lines driven outside a selected read");

  a_regs_hold_high: assert property (
    $past(bus_phase_i) |-> ($stable(ddr_ff) && $stable(out_ff))
  ) else $error("register changed without a falling bus clock");

  a_out_write_a: assert property (
    (wr_commit && lat_rs_ff == adp_pkg::SEL_A_DATA &&
     cr[0][`ADP_CR_ACCESS]) |=>
      (side_a_port_lines_o == $past(in_latch_ff)) && $stable(ddr_ff)
  ) else $error("output register A write lost");

  a_ddr_write_b: assert property (
    (wr_commit && lat_rs_ff == adp_pkg::SEL_B_DATA &&
     !cr[1][`ADP_CR_ACCESS]) |=>
      (side_b_port_lines_oe_o == $past(in_latch_ff)) && $stable(out_ff)
  ) else $error("direction register B write lost");

  a_side_isolation: assert property (
    (wr_commit && lat_rs_ff[1]) |=> $stable(ddr_ff[0]) && $stable(out_ff[0])
  ) else $error("side B write disturbed side A");

  a_reset_clears: assert property (
    disable iff (1'b0)
    rst |=> (ddr_ff == '0) && (out_ff == '0) && (cr[0] == `ADP_REG_RST) &&
            (cr[1] == `ADP_REG_RST)
  ) else $error("reset left a register set");

endmodule
`default_nettype wire

// file: sim/host_cpu_model.sv
// Processor bus master model driving clocked register cycles
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  // Clock
  input  wire logic       clk_i,
  // Bus pins
  output logic            bus_phase_o,
  output logic            rd_wr_o,
  output logic [2:0]      cs_o,
  output logic [1:0]      rs_o,
  output logic [7:0]      data_o,
  output logic            data_oe_o
);
  initial begin
    bus_phase_o = 1'b0;
    rd_wr_o     = 1'b1;
    cs_o        = 3'b001;
    rs_o        = 2'b00;
    data_o      = 8'h00;
    data_oe_o   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open a cycle: everything set together with the bus clock high phase
  task automatic start(input logic [1:0] rs, input logic rd,
                       input logic [7:0] d, input logic [2:0] cs);
    @(posedge clk_i);
    bus_phase_o <= 1'b1;
    rd_wr_o     <= rd;
    cs_o        <= cs;
    rs_o        <= rs;
    data_o      <= d;
    data_oe_o   <= ~rd;
  endtask

  // Close a cycle; selects held one edge past the fall so it is taken
  task automatic finish();
    @(posedge clk_i);
    bus_phase_o <= 1'b0;
    @(posedge clk_i);
    cs_o      <= 3'b001;
    data_oe_o <= 1'b0;
    rd_wr_o   <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: sim/dual_port_parallel_io_adapter_bench.sv
// Self-checking bench for the dual-side parallel I/O adapter
`timescale 1ns/100ps
`default_nettype none
module dual_port_parallel_io_adapter_bench;
  logic sys_clk, reset, rst_pin_n, ph, rw, bus_oe, cpu_oe;
  logic [2:0] cs;
  logic [1:0] rs;
  logic [7:0] cpu_d, bus_o, bus, bus_last, ext_a, ext_b;
  logic [7:0] a_o, a_oe, b_o, b_oe, pin_a, pin_b;
  logic a_irq_oe, b_irq_oe, a_c1, a_c2, b_c1, b_c2;
  logic a_irq_o, b_irq_o;
  logic a_s_o, a_s_oe, b_s_o, b_s_oe;
  int n_fail, check_count;

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Released bus lines have no pull: show the inverse of the last value
  assign bus   = bus_oe ? bus_o : (cpu_oe ? cpu_d : ~bus_last);
  assign pin_a = (a_oe & a_o) | (~a_oe & ext_a);
  assign pin_b = (b_oe & b_o) | (~b_oe & ext_b);
  always @(posedge sys_clk) bus_last <= bus;

  host_cpu_model cpu (.clk_i(sys_clk), .bus_phase_o(ph), .rd_wr_o(rw),
    .cs_o(cs), .rs_o(rs), .data_o(cpu_d), .data_oe_o(cpu_oe));

  dual_port_parallel_io_adapter DUT (
    .sys_clk_i(sys_clk), .reset_i(reset), .reset_in_n_i(rst_pin_n),
    .bus_phase_i(ph), .rd_wr_i(rw), .select_hi_first_i(cs[2]),
    .select_hi_second_i(cs[1]), .select_lo_n_i(cs[0]),
    .reg_sel_low_i(rs[0]), .reg_sel_high_i(rs[1]),
    .host_data_lines_i(bus), .host_data_lines_o(bus_o),
    .host_data_lines_oe_o(bus_oe),
    .side_a_irq_n_o(a_irq_o), .side_a_irq_n_oe_o(a_irq_oe),
    .side_b_irq_n_o(b_irq_o), .side_b_irq_n_oe_o(b_irq_oe),
    .side_a_port_lines_i(pin_a), .side_a_port_lines_o(a_o),
    .side_a_port_lines_oe_o(a_oe), .side_a_ctl_first_i(a_c1),
    .side_a_ctl_second_i(a_s_oe ? a_s_o : a_c2),
    .side_a_ctl_second_o(a_s_o), .side_a_ctl_second_oe_o(a_s_oe),
    .side_b_port_lines_i(pin_b), .side_b_port_lines_o(b_o),
    .side_b_port_lines_oe_o(b_oe), .side_b_ctl_first_i(b_c1),
    .side_b_ctl_second_i(b_s_oe ? b_s_o : b_c2),
    .side_b_ctl_second_o(b_s_o), .side_b_ctl_second_oe_o(b_s_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    cpu.start(a, 1'b0, d, 3'b110);
    cpu.finish();
    repeat (2) @(posedge sys_clk);
  endtask

  // Pull-up on the request lines: pin shows the drive only while enabled
  task automatic irq(input logic [1:0] exp);
    logic pa;
    logic pb;
    pa = a_irq_oe ? a_irq_o : 1'b1;
    pb = b_irq_oe ? b_irq_o : 1'b1;
    check("irq a pin", {7'h00, pa}, {7'h00, exp[1]});
    check("irq b pin", {7'h00, pb}, {7'h00, exp[0]});
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    cpu.start(a, 1'b1, 8'h00, 3'b110);
    repeat (2) @(posedge sys_clk);
    check("read data", bus_o, exp);
    check("data drive", {7'h00, bus_oe}, 8'h01);
    cpu.finish();
    repeat (2) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(2'b01, 8'h00);
    rd(2'b11, 8'h00);
    rd(2'b00, 8'h00);
    check("port oe", a_oe | b_oe, 8'h00);
    irq(2'b11);
  endtask

  task automatic t_ports();
    wr(2'b00, 8'hf0);
    wr(2'b10, 8'h0f);
    wr(2'b01, 8'h04);
    wr(2'b11, 8'h04);
    wr(2'b00, 8'h5a);
    wr(2'b10, 8'ha5);
    check("a oe", a_oe, 8'hf0);
    check("b oe", b_oe, 8'h0f);
    check("a out", a_o & a_oe, 8'h50);
    check("b out", b_o & b_oe, 8'h05);
    rd(2'b00, 8'h5c);
    rd(2'b10, 8'h35);
    wr(2'b01, 8'h00);
    rd(2'b00, 8'hf0);
  endtask

  // Wrong select patterns write nothing and never drive the bus
  task automatic t_select();
    logic [2:0] bad [4] = '{3'b010, 3'b100, 3'b111, 3'b000};
    foreach (bad[i]) begin
      cpu.start(2'b00, i[0], 8'h00, bad[i]);
      repeat (2) @(posedge sys_clk);
      check("unselected drive", {7'h00, bus_oe}, 8'h00);
      cpu.finish();
    end
    repeat (2) @(posedge sys_clk);
    check("unselected drive idle", {7'h00, bus_oe}, 8'h00);
    rd(2'b00, 8'hf0);
  endtask

  task automatic t_latch();
    wr(2'b01, 8'h04);
    cpu.start(2'b00, 1'b0, 8'h33, 3'b110);
    repeat (3) @(posedge sys_clk);
    check("out before fall", a_o, 8'h5a);
    cpu.finish();
    repeat (2) @(posedge sys_clk);
    check("out after fall", a_o, 8'h33);
  endtask

  task automatic t_ctl();
    wr(2'b01, 8'hff);
    rd(2'b01, 8'h3f);
    check("second oe", {7'h00, a_s_oe}, 8'h01);
    check("second level", {7'h00, a_s_o}, 8'h01);
    check("b second oe", {7'h00, b_s_oe}, 8'h00);
    // Drop the level before releasing, so no edge reaches the input
    wr(2'b01, 8'h37);
    check("second low", {7'h00, a_s_o}, 8'h00);
    wr(2'b01, 8'h07);
  endtask

  task automatic t_irq();
    a_c1 <= 1'b1;
    repeat (8) @(posedge sys_clk);
    irq(2'b01);
    rd(2'b01, 8'h87);
    rd(2'b00, 8'h3c);
    rd(2'b01, 8'h07);
    irq(2'b11);
    wr(2'b11, 8'h1c);
    b_c2 <= 1'b1;
    repeat (8) @(posedge sys_clk);
    irq(2'b10);
    rd(2'b11, 8'h5c);
    wr(2'b11, 8'h14);
    irq(2'b11);
    rd(2'b10, 8'h35);
    rd(2'b11, 8'h14);
    wr(2'b01, 8'h05);
    a_c1 <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(2'b01, 8'h85);
    irq(2'b01);
    wr(2'b11, 8'h07);
    b_c1 <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(2'b11, 8'h87);
    irq(2'b00);
  endtask

  task automatic t_pin_reset();
    rst_pin_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_pin_n <= 1'b1;
    @(posedge sys_clk);
    check("pin reset oe", a_oe | b_oe, 8'h00);
    check("pin reset out", a_o | b_o, 8'h00);
    irq(2'b11);
    rd(2'b01, 8'h00);
    rd(2'b00, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    check_count = 0;
    reset = 1'b1;
    rst_pin_n = 1'b1;
    ext_a = 8'h3c;
    ext_b = 8'h3c;
    {a_c1, a_c2, b_c1, b_c2} = 4'h0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_ports();
    t_select();
    t_latch();
    t_ctl();
    t_irq();
    t_pin_reset();
    results();
  end

  // Scenarios take well under a thousand cycles
  initial begin
    #(5000 * 100);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
